// file: rtl/zone_cmd_defines.svh
// constants of the active-state command link: codes, fields, status values, crc
`ifndef ZONE_CMD_DEFINES_SVH
`define ZONE_CMD_DEFINES_SVH

`define CODE_ZONE_SEL 4'h1
`define CODE_USER_RD 4'h2
`define CODE_USER_WR 4'h3
`define CODE_SYS_WR 4'h4
`define CODE_SYS_RD 4'h6
`define CODE_CRYPTO 4'h8
`define CODE_CHKSUM 4'h9
`define CODE_DESEL 4'ha
`define CODE_IDLE 4'hb
`define CODE_PWD 4'hc

`define ACK_OK 8'h00
`define ACK_FAIL 8'h01
`define ACK_FAIL_NIB 4'h1
`define STATUS_OK 8'h00
`define STATUS_PARAM_BAD 8'ha1

`define TEAR_BIT 7
`define RSVD_HI 6
`define RSVD_LO 4
`define ZONE_HI 3
`define ZONE_COUNT 5'h10
`define CNT_MAX_V1 4'h8

`define CRC_INIT 16'hffff
`define CRC_POLY 16'h8408
`define CRC_RESIDUE 16'hf0b8

`endif

// file: rtl/zone_cmd_pkg.sv
// shared types and helpers of the active-state command link
`include "zone_cmd_defines.svh"
package zone_cmd_pkg;

	typedef enum logic [8:0] {
		C_IDLE = 9'h001,
		C_EXEC = 9'h002,
		C_ECHO = 9'h004,
		C_ACK = 9'h008,
		C_DATA = 9'h010,
		C_STAT = 9'h020,
		C_CRC1 = 9'h040,
		C_CRC2 = 9'h080,
		C_DONE = 9'h100
	} card_state_type;

	typedef enum logic [5:0] {
		R_IDLE = 6'h01,
		R_CMD = 6'h02,
		R_PARAM = 6'h04,
		R_CRC1 = 6'h08,
		R_CRC2 = 6'h10,
		R_WAIT = 6'h20
	} reader_state_type;

	// one byte of the type b crc, lsb first
	function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	function automatic logic code_supported(input logic [3:0] code);
		case (code)
			`CODE_ZONE_SEL, `CODE_USER_RD, `CODE_USER_WR, `CODE_SYS_WR, `CODE_SYS_RD,
			`CODE_CRYPTO, `CODE_CHKSUM, `CODE_DESEL, `CODE_IDLE, `CODE_PWD: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

endpackage

// file: rtl/zone_cmd_link.sv
// byte link between the reader and the card
`timescale 1ns/1ps
`default_nettype none
interface zone_cmd_link;
	logic req_valid;
	logic [7:0] req_data;
	logic req_last;
	logic rsp_valid;
	logic [7:0] rsp_data;
	logic rsp_last;

	modport card (input req_valid, input req_data, input req_last,
		output rsp_valid, output rsp_data, output rsp_last);
	modport reader (output req_valid, output req_data, output req_last,
		input rsp_valid, input rsp_data, input rsp_last);
endinterface
`default_nettype wire

// file: rtl/zone_cmd_card.sv
// card end: command filter, zone select and common response framing
`timescale 1ns/1ps
`default_nettype none
`include "zone_cmd_defines.svh"

// Summary of operation
// - high nibble identifier, low nibble command code
// - unknown command code dropped, no reply
// - foreign identifier dropped, no reply
// - every reply holds five bytes or more
// - first reply byte echoes command byte
// - status byte then two crc bytes
// - data bytes between acknowledge and status
// - acknowledge zero ok, one general failure
// - password failure: count high, 0001 low
// - crypto failure: count high, 0001 low
// - first variant counts zero to eight
// - second variant counts to fifteen, locked
// - status gives state or first error
// - one selected zone for user access
// - reader selects zone before user access
// - tear guard holds until next successful select
// - zone select answered only when active
// - param: tear bit, three zeros, zone
// - tear bit one selects guarded writes
// - corrupted zone select frame dropped silently
// - select status 00 ok, a1 bad
// - identifier is the one assigned at activation
module zone_cmd_card (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	zone_cmd_link.card link,
	input wire logic active_i,
	input wire logic [3:0] card_slot_ident_i,
	input wire logic variant_i,
	input wire logic [3:0] pwd_fail_cnt_i,
	input wire logic [3:0] auth_fail_cnt_i,
	output logic exec_start_o,
	output logic [3:0] exec_code_o,
	output logic [7:0] exec_param_o,
	input wire logic exec_done_i,
	input wire logic exec_fail_i,
	input wire logic [7:0] exec_status_i,
	input wire logic [7:0] exec_len_i,
	output logic data_req_o,
	input wire logic [7:0] data_i,
	output logic [3:0] zone_o,
	output logic zone_valid_o,
	output logic tear_guard_select_o
);

	zone_cmd_pkg::card_state_type state;
	zone_cmd_pkg::card_state_type next_state;
	logic [7:0] cmd_byte;
	logic [7:0] param_byte;
	logic [1:0] rx_cnt;
	logic [15:0] rx_crc;
	logic [15:0] next_rx_crc;
	logic frame_ok;
	logic accept;
	logic zone_param_ok;
	logic [7:0] ack_byte;
	logic [7:0] status_byte;
	logic [7:0] data_left;
	logic [15:0] tx_crc;

	// ----------------------------------------------------------------
	// receive and frame check
	// ----------------------------------------------------------------
	assign next_rx_crc = zone_cmd_pkg::crc_byte(rx_crc, link.req_data);
	// residue check covers the frame and its crc; short frames are noise
	assign frame_ok = link.req_valid && link.req_last && (rx_cnt == 2'd3)
		&& (next_rx_crc == `CRC_RESIDUE);
	assign accept = frame_ok && (state == zone_cmd_pkg::C_IDLE) && active_i
		&& (cmd_byte[7:4] == card_slot_ident_i)
		&& zone_cmd_pkg::code_supported(cmd_byte[3:0]);

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_cnt <= 2'd0;
			rx_crc <= `CRC_INIT;
			cmd_byte <= 8'h00;
			param_byte <= 8'h00;
		end else if (link.req_valid) begin
			if (link.req_last) begin
				rx_cnt <= 2'd0;
				rx_crc <= `CRC_INIT;
			end else begin
				if (rx_cnt == 2'd0) begin
					cmd_byte <= link.req_data;
				end
				if (rx_cnt == 2'd1) begin
					param_byte <= link.req_data;
				end
				if (rx_cnt != 2'd3) begin
					rx_cnt <= rx_cnt + 2'd1;
				end
				rx_crc <= next_rx_crc;
			end
		end
	end

	// ----------------------------------------------------------------
	// zone select
	// ----------------------------------------------------------------
	// reserved bits must be zero and the zone must exist
	assign zone_param_ok = (param_byte[`RSVD_HI:`RSVD_LO] == 3'd0)
		&& ({1'b0, param_byte[`ZONE_HI:0]} < `ZONE_COUNT);

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			zone_o <= 4'h0;
			zone_valid_o <= 1'b0;
			tear_guard_select_o <= 1'b0;
		end else if (accept && (cmd_byte[3:0] == `CODE_ZONE_SEL) && zone_param_ok) begin
			zone_o <= param_byte[`ZONE_HI:0];
			zone_valid_o <= 1'b1;
			tear_guard_select_o <= param_byte[`TEAR_BIT];
		end
	end

	// ----------------------------------------------------------------
	// command dispatch to the user side
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			exec_start_o <= 1'b0;
			exec_code_o <= 4'h0;
			exec_param_o <= 8'h00;
		end else begin
			exec_start_o <= accept && (cmd_byte[3:0] != `CODE_ZONE_SEL);
			if (accept) begin
				exec_code_o <= cmd_byte[3:0];
				exec_param_o <= param_byte;
			end
		end
	end

	// attempts count, clamped to what the variant can show
	function automatic logic [7:0] fail_ack(input logic [3:0] cnt, input logic v2);
		logic [3:0] c;
		c = (!v2 && (cnt > `CNT_MAX_V1)) ? `CNT_MAX_V1 : cnt;
		return {c, `ACK_FAIL_NIB};
	endfunction

	// ----------------------------------------------------------------
	// outcome latch
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_byte <= `ACK_OK;
			status_byte <= `STATUS_OK;
			data_left <= 8'h00;
		end else if (accept && (cmd_byte[3:0] == `CODE_ZONE_SEL)) begin
			ack_byte <= zone_param_ok ? `ACK_OK : `ACK_FAIL;
			status_byte <= zone_param_ok ? `STATUS_OK : `STATUS_PARAM_BAD;
			data_left <= 8'h00;
		end else if (state == zone_cmd_pkg::C_EXEC && exec_done_i) begin
			// status comes from the executor, which reports only its first error
			status_byte <= exec_status_i;
			data_left <= exec_len_i;
			if (!exec_fail_i) begin
				ack_byte <= `ACK_OK;
			end else if (exec_code_o == `CODE_PWD) begin
				ack_byte <= fail_ack(pwd_fail_cnt_i, variant_i);
			end else if (exec_code_o == `CODE_CRYPTO) begin
				ack_byte <= fail_ack(auth_fail_cnt_i, variant_i);
			end else begin
				ack_byte <= `ACK_FAIL;
			end
		end else if (data_req_o) begin
			data_left <= data_left - 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	assign data_req_o = (state == zone_cmd_pkg::C_DATA);

	always_comb begin
		next_state = state;
		case (state)
			zone_cmd_pkg::C_IDLE: begin
				if (accept) begin
					next_state = (cmd_byte[3:0] == `CODE_ZONE_SEL) ? zone_cmd_pkg::C_ECHO : zone_cmd_pkg::C_EXEC;
				end
			end
			zone_cmd_pkg::C_EXEC: begin
				if (exec_done_i) begin
					next_state = zone_cmd_pkg::C_ECHO;
				end
			end
			zone_cmd_pkg::C_ECHO: next_state = zone_cmd_pkg::C_ACK;
			zone_cmd_pkg::C_ACK: begin
				next_state = (data_left != 8'h00) ? zone_cmd_pkg::C_DATA : zone_cmd_pkg::C_STAT;
			end
			zone_cmd_pkg::C_DATA: begin
				if (data_left == 8'h01) begin
					next_state = zone_cmd_pkg::C_STAT;
				end
			end
			zone_cmd_pkg::C_STAT: next_state = zone_cmd_pkg::C_CRC1;
			zone_cmd_pkg::C_CRC1: next_state = zone_cmd_pkg::C_CRC2;
			zone_cmd_pkg::C_CRC2: next_state = zone_cmd_pkg::C_DONE;
			zone_cmd_pkg::C_DONE: next_state = zone_cmd_pkg::C_IDLE;
			default: next_state = zone_cmd_pkg::C_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= zone_cmd_pkg::C_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// response bytes, registered one cycle behind the sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			link.rsp_valid <= 1'b0;
			link.rsp_data <= 8'h00;
			link.rsp_last <= 1'b0;
			tx_crc <= `CRC_INIT;
		end else begin
			link.rsp_valid <= 1'b0;
			link.rsp_last <= 1'b0;
			case (state)
				zone_cmd_pkg::C_ECHO: begin
					link.rsp_valid <= 1'b1;
					link.rsp_data <= cmd_byte;
					tx_crc <= zone_cmd_pkg::crc_byte(`CRC_INIT, cmd_byte);
				end
				zone_cmd_pkg::C_ACK: begin
					link.rsp_valid <= 1'b1;
					link.rsp_data <= ack_byte;
					tx_crc <= zone_cmd_pkg::crc_byte(tx_crc, ack_byte);
				end
				zone_cmd_pkg::C_DATA: begin
					link.rsp_valid <= 1'b1;
					link.rsp_data <= data_i;
					tx_crc <= zone_cmd_pkg::crc_byte(tx_crc, data_i);
				end
				zone_cmd_pkg::C_STAT: begin
					link.rsp_valid <= 1'b1;
					link.rsp_data <= status_byte;
					tx_crc <= zone_cmd_pkg::crc_byte(tx_crc, status_byte);
				end
				zone_cmd_pkg::C_CRC1: begin
					link.rsp_valid <= 1'b1;
					link.rsp_data <= ~tx_crc[7:0];
				end
				zone_cmd_pkg::C_CRC2: begin
					// echo, ack, status and two crc bytes give five at least
					link.rsp_valid <= 1'b1;
					link.rsp_data <= ~tx_crc[15:8];
					link.rsp_last <= 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// file: rtl/zone_cmd_reader.sv
// reader end: sends two-byte commands with crc and decodes the reply
`timescale 1ns/1ps
`default_nettype none
`include "zone_cmd_defines.svh"

module zone_cmd_reader (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	zone_cmd_link.reader link,
	input wire logic send_i,
	input wire logic [7:0] send_cmd_i,
	input wire logic [7:0] send_param_i,
	output logic busy_o,
	output logic order_err_o,
	output logic rsp_done_o,
	output logic [7:0] rsp_echo_o,
	output logic [7:0] rsp_ack_o,
	output logic [7:0] rsp_status_o,
	output logic [7:0] rsp_len_o,
	output logic rsp_crc_ok_o,
	output logic zone_known_o
);

	zone_cmd_pkg::reader_state_type state;
	logic [7:0] cmd_byte;
	logic [7:0] param_byte;
	logic [15:0] tx_crc;
	logic [15:0] rx_crc;
	logic [15:0] next_rx_crc;
	logic [7:0] prev1;
	logic [7:0] prev2;
	logic is_user_access;

	assign busy_o = (state != zone_cmd_pkg::R_IDLE);
	assign is_user_access = (send_cmd_i[3:0] == `CODE_USER_RD) || (send_cmd_i[3:0] == `CODE_USER_WR);
	assign next_rx_crc = zone_cmd_pkg::crc_byte(rx_crc, link.rsp_data);

	// ----------------------------------------------------------------
	// command sender
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= zone_cmd_pkg::R_IDLE;
			cmd_byte <= 8'h00;
			param_byte <= 8'h00;
			tx_crc <= `CRC_INIT;
			order_err_o <= 1'b0;
			link.req_valid <= 1'b0;
			link.req_data <= 8'h00;
			link.req_last <= 1'b0;
		end else begin
			order_err_o <= 1'b0;
			link.req_valid <= 1'b0;
			link.req_last <= 1'b0;
			case (state)
				zone_cmd_pkg::R_IDLE: begin
					if (send_i) begin
						// user access before a zone select acknowledged ok with a good crc is refused here
						if (is_user_access && !zone_known_o) begin
							order_err_o <= 1'b1;
						end else begin
							cmd_byte <= send_cmd_i;
							param_byte <= send_param_i;
							state <= zone_cmd_pkg::R_CMD;
						end
					end
				end
				zone_cmd_pkg::R_CMD: begin
					link.req_valid <= 1'b1;
					link.req_data <= cmd_byte;
					tx_crc <= zone_cmd_pkg::crc_byte(`CRC_INIT, cmd_byte);
					state <= zone_cmd_pkg::R_PARAM;
				end
				zone_cmd_pkg::R_PARAM: begin
					link.req_valid <= 1'b1;
					link.req_data <= param_byte;
					tx_crc <= zone_cmd_pkg::crc_byte(tx_crc, param_byte);
					state <= zone_cmd_pkg::R_CRC1;
				end
				zone_cmd_pkg::R_CRC1: begin
					link.req_valid <= 1'b1;
					link.req_data <= ~tx_crc[7:0];
					state <= zone_cmd_pkg::R_CRC2;
				end
				zone_cmd_pkg::R_CRC2: begin
					link.req_valid <= 1'b1;
					link.req_data <= ~tx_crc[15:8];
					link.req_last <= 1'b1;
					state <= zone_cmd_pkg::R_WAIT;
				end
				zone_cmd_pkg::R_WAIT: begin
					// a silent card leaves the wait to the user: send_i aborts it
					if ((link.rsp_valid && link.rsp_last) || send_i) begin
						state <= zone_cmd_pkg::R_IDLE;
					end
				end
				default: state <= zone_cmd_pkg::R_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// reply decoder
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_crc <= `CRC_INIT;
			prev1 <= 8'h00;
			prev2 <= 8'h00;
			rsp_len_o <= 8'h00;
			rsp_echo_o <= 8'h00;
			rsp_ack_o <= 8'h00;
			rsp_status_o <= 8'h00;
			rsp_crc_ok_o <= 1'b0;
			rsp_done_o <= 1'b0;
			zone_known_o <= 1'b0;
		end else begin
			rsp_done_o <= 1'b0;
			if (link.rsp_valid) begin
				prev1 <= link.rsp_data;
				prev2 <= prev1;
				if (rsp_len_o == 8'h00) begin
					rsp_echo_o <= link.rsp_data;
				end
				if (rsp_len_o == 8'h01) begin
					rsp_ack_o <= link.rsp_data;
				end
				if (link.rsp_last) begin
					rx_crc <= `CRC_INIT;
					rsp_len_o <= 8'h00;
					rsp_status_o <= prev2;
					rsp_crc_ok_o <= (next_rx_crc == `CRC_RESIDUE) && (rsp_len_o >= 8'h04)
						&& (rsp_echo_o == cmd_byte);
					rsp_done_o <= 1'b1;
					if ((cmd_byte[3:0] == `CODE_ZONE_SEL) && (rsp_ack_o == `ACK_OK)
						&& (next_rx_crc == `CRC_RESIDUE)) begin
						zone_known_o <= 1'b1;
					end
				end else begin
					rx_crc <= next_rx_crc;
					rsp_len_o <= rsp_len_o + 8'h01;
				end
			end
		end
	end

endmodule
`default_nettype wire

// file: bench/zone_cmd_checker.sv
// link checker: reply framing, echo, crc and zone select replies
`timescale 1ns/1ps
`default_nettype none
`include "zone_cmd_defines.svh"
module zone_cmd_checker (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic req_valid,
	input wire logic [7:0] req_data,
	input wire logic req_last,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic rsp_last
);
	logic [7:0] cnt;
	logic [2:0] qcnt;
	logic [7:0] cmd;
	logic [7:0] prm;
	logic [15:0] rcrc;
	logic [15:0] qcrc;
	logic pend;
	logic zone_first;

	function automatic logic [15:0] crc_next(input logic [15:0] c, input logic [7:0] d);
		c = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 8'h00;
			rcrc <= `CRC_INIT;
		end else if (rsp_valid) begin
			cnt <= rsp_last ? 8'h00 : cnt + 8'h01;
			rcrc <= rsp_last ? `CRC_INIT : crc_next(rcrc, rsp_data);
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			qcnt <= 3'h0;
			qcrc <= `CRC_INIT;
			cmd <= 8'h00;
			prm <= 8'h00;
		end else if (req_valid) begin
			qcnt <= req_last ? 3'h0 : qcnt + 3'h1;
			qcrc <= req_last ? `CRC_INIT : crc_next(qcrc, req_data);
			if (qcnt == 3'h0) cmd <= req_data;
			if (qcnt == 3'h1) prm <= req_data;
		end
	end

	// weak on purpose: a dropped frame leaves this set until the next frame starts
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) pend <= 1'b0;
		else if (req_valid) pend <= req_last;
		else if (rsp_valid && rsp_last) pend <= 1'b0;
	end

	assign zone_first = rsp_valid && cnt == 8'h00 && rsp_data[3:0] == `CODE_ZONE_SEL;

	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_zone_ok;
		rsp_valid && rsp_data == `ACK_OK ##1 rsp_valid && rsp_data == `STATUS_OK;
	endsequence
	sequence s_zone_bad;
		rsp_valid && rsp_data == `ACK_FAIL ##1 rsp_valid && rsp_data == `STATUS_PARAM_BAD;
	endsequence
	sequence s_crc_tail;
		rsp_valid && !rsp_last ##1 rsp_valid && rsp_last;
	endsequence

	property p_rsp_len; rsp_valid && rsp_last |-> cnt >= 8'h04; endproperty
	a_rsp_len: assert property (p_rsp_len) else $error("reply shorter than five bytes");
	property p_echo; rsp_valid && cnt == 8'h00 |-> rsp_data == cmd; endproperty
	a_echo: assert property (p_echo) else $error("first reply byte is not the command");
	property p_rsp_crc; rsp_valid && rsp_last |-> crc_next(rcrc, rsp_data) == `CRC_RESIDUE; endproperty
	a_rsp_crc: assert property (p_rsp_crc) else $error("reply crc wrong");
	property p_req_crc; req_valid && req_last |-> qcnt == 3'h3 && crc_next(qcrc, req_data) == `CRC_RESIDUE; endproperty
	a_req_crc: assert property (p_req_crc) else $error("request frame length or crc wrong");
	property p_burst; rsp_valid && !rsp_last |=> rsp_valid; endproperty
	a_burst: assert property (p_burst) else $error("gap inside a reply");
	property p_quiet; rsp_valid && rsp_last |=> !rsp_valid [*4]; endproperty
	a_quiet: assert property (p_quiet) else $error("reply bytes after the last one");
	property p_asked; rsp_valid && cnt == 8'h00 |-> pend; endproperty
	a_asked: assert property (p_asked) else $error("reply without a frame");
	property p_ack;
		rsp_valid && cnt == 8'h01 |-> rsp_data == `ACK_OK || rsp_data[3:0] == `ACK_FAIL_NIB &&
			(rsp_data[7:4] == 4'h0 || cmd[3:0] == `CODE_PWD || cmd[3:0] == `CODE_CRYPTO);
	endproperty
	a_ack: assert property (p_ack) else $error("bad acknowledge byte");
	property p_zone_ok; zone_first && prm[6:4] == 3'h0 |=> s_zone_ok ##1 s_crc_tail; endproperty
	a_zone_ok: assert property (p_zone_ok) else $error("zone select success reply wrong");
	property p_zone_bad; zone_first && prm[6:4] != 3'h0 |=> s_zone_bad ##1 s_crc_tail; endproperty
	a_zone_bad: assert property (p_zone_bad) else $error("zone select refusal reply wrong");
endmodule
`default_nettype wire

// file: bench/tb_active_cmd_decode_zone_select.sv
// bench: reader and card on one link, a second card fed hand-made frames
`timescale 1ns/1ps
`default_nettype none
`include "zone_cmd_defines.svh"
module tb_active_cmd_decode_zone_select;
	typedef struct {logic [7:0] echo; logic [7:0] ack; logic [7:0] status;} note_type;
	localparam logic [3:0] cmd_codes [9] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
	localparam logic [3:0] junk_codes [6] = '{4'h0, 4'h5, 4'h7, 4'hd, 4'he, 4'hf};
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic send_i = 1'b0;
	logic [7:0] send_cmd_i = 8'h00;
	logic [7:0] send_param_i = 8'h00;
	logic active_i = 1'b1;
	logic variant_i = 1'b0;
	logic [3:0] ident = 4'h0;
	logic [3:0] pwd_cnt = 4'h0;
	logic [3:0] auth_cnt = 4'h0;
	logic exec_done_i = 1'b0;
	logic exec_fail_i = 1'b0;
	logic [7:0] exec_status_i = 8'h00;
	logic [7:0] exec_len_i = 8'h00;
	logic [7:0] data_i = 8'h00;
	logic busy, order_err, done, crc_ok, exec_start, tear, want_tear, zone_set, zone_known;
	logic [7:0] echo, ack, status, exec_param, plan_cmd, plan_param;
	logic [3:0] exec_code, zone, zone_b, want_zone;
	int plan_wait, bad_count = 0, total_checks = 0, exec_seen = 0;
	note_type notes[$];
	zone_cmd_link link ();
	zone_cmd_link link_b ();

	zone_cmd_reader zone_cmd_reader_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link), .send_i(send_i),
		.send_cmd_i(send_cmd_i), .send_param_i(send_param_i), .busy_o(busy), .order_err_o(order_err),
		.rsp_done_o(done), .rsp_echo_o(echo), .rsp_ack_o(ack), .rsp_status_o(status), .rsp_len_o(),
		.rsp_crc_ok_o(crc_ok), .zone_known_o(zone_known));
	zone_cmd_card zone_cmd_card_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link), .active_i(active_i),
		.card_slot_ident_i(ident), .variant_i(variant_i), .pwd_fail_cnt_i(pwd_cnt), .auth_fail_cnt_i(auth_cnt),
		.exec_start_o(exec_start), .exec_code_o(exec_code), .exec_param_o(exec_param), .exec_done_i(exec_done_i),
		.exec_fail_i(exec_fail_i), .exec_status_i(exec_status_i), .exec_len_i(exec_len_i), .data_req_o(),
		.data_i(data_i), .zone_o(zone), .zone_valid_o(zone_set), .tear_guard_select_o(tear));
	zone_cmd_card zone_cmd_card_b_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link_b), .active_i(active_i),
		.card_slot_ident_i(ident), .variant_i(variant_i), .pwd_fail_cnt_i(pwd_cnt), .auth_fail_cnt_i(auth_cnt),
		.exec_start_o(), .exec_code_o(), .exec_param_o(), .exec_done_i(exec_done_i), .exec_fail_i(exec_fail_i),
		.exec_status_i(exec_status_i), .exec_len_i(exec_len_i), .data_req_o(), .data_i(data_i), .zone_o(zone_b),
		.zone_valid_o(), .tear_guard_select_o());
	zone_cmd_checker zone_cmd_checker_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_valid(link.req_valid),
		.req_data(link.req_data), .req_last(link.req_last), .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data),
		.rsp_last(link.rsp_last));

	always #2 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) data_i <= 8'($urandom);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
		total_checks++;
		if (seen !== want) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] d);
		c = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	// first variant saturates the attempt count at eight
	function automatic logic [7:0] fail_ack(input logic [3:0] code, input logic v, input logic [3:0] p,
		input logic [3:0] a);
		logic [3:0] n;
		n = (code == `CODE_PWD) ? p : a;
		if (!v && n > `CNT_MAX_V1) n = `CNT_MAX_V1;
		return (code == `CODE_PWD || code == `CODE_CRYPTO) ? {n, `ACK_FAIL_NIB} : `ACK_FAIL;
	endfunction

	task automatic wait_idle();
		for (int n = 0; busy !== 1'b0; n++) begin
			@(negedge ref_clk_i);
			if (n > 200) begin
				bad_count++;
				$display("[ERR] busy expected low seen high");
				stop_test();
			end
		end
	endtask

	task automatic send(input logic [7:0] cmd, input logic [7:0] param);
		wait_idle();
		@(posedge ref_clk_i);
		send_i <= 1'b1;
		send_cmd_i <= cmd;
		send_param_i <= param;
		@(posedge ref_clk_i);
		send_i <= 1'b0;
	endtask

	task automatic run(input logic [7:0] cmd, input logic [7:0] param, input logic [7:0] a, input logic [7:0] s);
		notes.push_back('{cmd, a, s});
		send(cmd, param);
		// busy rises only once the send edge has been taken
		@(negedge ref_clk_i);
		wait_idle();
	endtask

	// the card must stay silent; a pulse in the wait state lets the reader give up
	task automatic drop(input logic [7:0] cmd);
		send(cmd, 8'($urandom));
		repeat (24) @(posedge ref_clk_i);
		send_i <= 1'b1;
		@(posedge ref_clk_i);
		send_i <= 1'b0;
		wait_idle();
	endtask

	task automatic raw(input logic [7:0] cmd, input logic [7:0] prm, input logic spoil, input int want);
		logic [15:0] c;
		logic [7:0] b [4];
		logic [7:0] first;
		int n;
		c = ~crc_b(crc_b(`CRC_INIT, cmd), prm);
		b = '{cmd, prm, c[7:0] ^ {7'h00, spoil}, c[15:8]};
		n = 0;
		first = 8'h00;
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk_i);
			link_b.req_valid <= 1'b1;
			link_b.req_data <= b[i];
			link_b.req_last <= (i == 3);
		end
		@(posedge ref_clk_i);
		link_b.req_valid <= 1'b0;
		link_b.req_last <= 1'b0;
		link_b.req_data <= ~b[3];
		repeat (16) begin
			@(negedge ref_clk_i);
			if (link_b.rsp_valid === 1'b1 && n == 0) first = link_b.rsp_data;
			if (link_b.rsp_valid === 1'b1) n++;
		end
		check("raw reply bytes", 8'(n), 8'(want));
		if (want > 0) check("raw echo", first, cmd);
	endtask

	// ----------------------------------------
	// reply watcher and executor
	// ----------------------------------------
	always @(negedge ref_clk_i) begin
		note_type n;
		if (done === 1'b1 && notes.size() == 0) begin
			bad_count++;
			$display("[ERR] reply expected none seen %h", echo);
		end else if (done === 1'b1) begin
			n = notes.pop_front();
			check("echo", echo, n.echo);
			check("ack", ack, n.ack);
			check("status", status, n.status);
			check("crc ok", {7'h00, crc_ok}, 8'h01);
		end
	end

	initial begin
		forever begin
			@(negedge ref_clk_i);
			if (exec_start === 1'b1) begin
				exec_seen++;
				check("exec code", {4'h0, exec_code}, {4'h0, plan_cmd[3:0]});
				check("exec param", exec_param, plan_param);
				repeat (plan_wait) @(posedge ref_clk_i);
				exec_done_i <= 1'b1;
				@(posedge ref_clk_i);
				exec_done_i <= 1'b0;
			end
		end
	end

	initial begin
		logic [7:0] p;
		logic [3:0] id, pc, ac;
		logic v;
		int n;
		link_b.req_valid = 1'b0;
		link_b.req_data = 8'h00;
		link_b.req_last = 1'b0;
		void'($urandom(60));
		id = 4'($urandom);
		repeat (16) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		ident <= id;
		send({id, `CODE_USER_RD}, 8'h00);
		n = 0;
		repeat (8) begin
			@(negedge ref_clk_i);
			if (order_err === 1'b1) n++;
		end
		check("order refusal", 8'(n), 8'h01);
		check("zone known early", {7'h00, zone_known}, 8'h00);
		check("zone valid early", {7'h00, zone_set}, 8'h00);
		for (int i = 0; i < 6; i++) begin
			p = 8'($urandom);
			if (i % 3 == 2) p[4] = 1'b1;
			else p[6:4] = 3'h0;
			run({id, `CODE_ZONE_SEL}, p, p[6:4] != 0 ? `ACK_FAIL : `ACK_OK, p[6:4] != 0 ? `STATUS_PARAM_BAD : 8'h00);
			if (p[6:4] == 3'h0) want_zone = p[3:0];
			if (p[6:4] == 3'h0) want_tear = p[7];
			check("zone", {4'h0, zone}, {4'h0, want_zone});
			check("tear guard", {7'h00, tear}, {7'h00, want_tear});
		end
		check("zone valid", {7'h00, zone_set}, 8'h01);
		check("zone known", {7'h00, zone_known}, 8'h01);
		for (int r = 0; r < 2; r++) begin
			foreach (cmd_codes[k]) begin
				v = 1'($urandom);
				pc = 4'($urandom_range(15, 9));
				ac = 4'($urandom);
				p = 8'($urandom);
				@(posedge ref_clk_i);
				exec_fail_i <= (r == 1);
				exec_status_i <= p;
				exec_len_i <= 8'($urandom_range(3, 0));
				variant_i <= v;
				pwd_cnt <= pc;
				auth_cnt <= ac;
				plan_cmd = {id, cmd_codes[k]};
				plan_param = 8'($urandom);
				plan_wait = $urandom_range(4, 1);
				run(plan_cmd, plan_param, r == 1 ? fail_ack(cmd_codes[k], v, pc, ac) : `ACK_OK, p);
			end
		end
		foreach (junk_codes[k]) drop({id, junk_codes[k]});
		drop({~id, `CODE_ZONE_SEL});
		@(posedge ref_clk_i);
		active_i <= 1'b0;
		drop({id, `CODE_ZONE_SEL});
		check("exec starts", 8'(exec_seen), 8'h12);
		check("zone after drops", {4'h0, zone}, {4'h0, want_zone});
		id = id + 4'h1;
		@(posedge ref_clk_i);
		active_i <= 1'b1;
		ident <= id;
		run({id, `CODE_ZONE_SEL}, 8'h8f, `ACK_OK, `STATUS_OK);
		check("zone new ident", {4'h0, zone}, 8'h0f);
		drop({id - 4'h1, `CODE_ZONE_SEL});
		raw({id, `CODE_ZONE_SEL}, 8'h0c, 1'b0, 5);
		check("raw zone", {4'h0, zone_b}, 8'h0c);
		raw({id, `CODE_ZONE_SEL}, 8'h03, 1'b1, 0);
		check("raw zone kept", {4'h0, zone_b}, 8'h0c);
		repeat (4) @(negedge ref_clk_i);
		stop_test();
	end
endmodule
`default_nettype wire
